// file: usp_consts.vh
// Constants for the serial port SPI block: offsets, fields, reset values, rates
`ifndef USP_CONSTS_VH
`define USP_CONSTS_VH

`define USP_ADDR_W 2
`define USP_OFS_MODE_CTRL 2'h0
`define USP_OFS_FORMAT 2'h1
`define USP_OFS_DATA 2'h2

`define USP_RST_MODE_CTRL 8'he0
`define USP_RST_FORMAT 8'h00
`define USP_RST_DATA 8'h00

`define USP_C0_MODE_HI 7
`define USP_C0_MODE_LO 5
`define USP_C0_PROTO 4
`define USP_C0_DEB_HI 3
`define USP_C0_DEB_LO 2
`define USP_C0_EN 1
`define USP_C0_ICF 0

`define USP_C2_SPARE_HI 7
`define USP_C2_SPARE_LO 6
`define USP_C2_CKPOLB 5
`define USP_C2_CKEG 4
`define USP_C2_MLS 3
`define USP_C2_CSEN 2
`define USP_C2_WCOL 1
`define USP_C2_TRF 0

`define USP_MODE_DIV4 3'h0
`define USP_MODE_DIV16 3'h1
`define USP_MODE_DIV64 3'h2
`define USP_MODE_SUB 3'h3
`define USP_MODE_TMR 3'h4
`define USP_MODE_SLAVE 3'h5
`define USP_MODE_I2C 3'h6
`define USP_MODE_UNUSED 3'h7

`define USP_HALF_DIV4 5'h01
`define USP_HALF_DIV16 5'h07
`define USP_HALF_DIV64 5'h1f
`define USP_LAST_EDGE 4'hf

`endif

// file: usp_sync2.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module usp_sync2 #(
    parameter W = 3
) (
    input wire clk_i, // System clock
    input wire reset_n_i, // Async reset, active low
    input wire [W-1:0] async_i, // Asynchronous levels
    output wire [W-1:0] sync_o // Synchronised levels
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_reg <= {W{1'b1}};
            sync_reg <= {W{1'b1}};
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule // usp_sync2

// file: usp_rate_gen.v
// Master bit-rate generator: one pulse per serial clock half period
`timescale 1ns/1ps
`include "usp_consts.vh"
module usp_rate_gen (
    input wire clk_i, // System clock
    input wire reset_n_i, // Async reset, active low
    input wire run_i, // Count while a master transfer runs
    input wire [2:0] mode_i, // Mode field
    input wire sub_tick_i, // Subsystem clock half-period pulse
    input wire tmr_match_i, // Timer period-match pulse
    output reg tick_o // Half-period pulse
);
    reg [4:0] cnt_reg;
    reg [4:0] half_lim;

    always @* begin
        case (mode_i)
            `USP_MODE_DIV4: half_lim = `USP_HALF_DIV4;
            `USP_MODE_DIV16: half_lim = `USP_HALF_DIV16;
            default: half_lim = `USP_HALF_DIV64;
        endcase
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= 5'h00;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_reg <= 5'h00;
            tick_o <= 1'b0;
        end else if (mode_i == `USP_MODE_SUB) begin
            tick_o <= sub_tick_i;
        end else if (mode_i == `USP_MODE_TMR) begin
            // Each match toggles the clock, giving half the match rate
            tick_o <= tmr_match_i;
        end else if (cnt_reg == half_lim) begin
            cnt_reg <= 5'h00;
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 5'h01;
            tick_o <= 1'b0;
        end
    end
endmodule // usp_rate_gen

// file: usp_spi_port.v
// SPI personality of the multi-protocol serial module
`timescale 1ns/1ps
`include "usp_consts.vh"
// Summary of operation
// - Mode 000-100 with protocol bit clear: master at fsys/4, /16, /64, sub clock, timer/2.
// - Bit 4 set selects UART; it must be zero for SPI.
// - Enable bit clear releases the pins and idles the block.
// - Raising enable leaves all control contents as they were.
// - Slave deselected mid-byte sets incomplete and completion flags.
// - Software setting the incomplete flag never sets completion.
// - Polarity bit zero idles the clock high, one idles it low.
// - Capture edge bit picks rising or falling capture per polarity.
// - Order bit zero sends LSB first, one MSB first.
// - Select-pin bit zero floats the select pin; one makes it active.
// - Data write during a transfer is dropped and sets sticky collision.
// - Completion flag clears at start, sets at end, software clears it.
// - One data register holds transmit byte before, received byte after.
// - Format and data registers only reachable when SPI mode is selected.
// - Two spare format bits store and read back.
// - Debounce bits are stored but do not affect SPI.
// - Master write starts full-duplex transfer; slave shifts on received clock.
// - Enabled with select on: input floats, output high (slave with edge bit set: first bit), clock idles or floats.
// - Slave with select-pin control off is always selected.
module usp_spi_port (
    input wire clk_i, // System clock, 100 MHz
    input wire reset_n_i, // Async reset, active low
    input wire [1:0] addr_i, // Register address
    input wire [7:0] wdata_i, // Write data
    input wire wr_i, // Write strobe
    input wire rd_i, // Read strobe
    output reg [7:0] rdata_o, // Read data, cycle after strobe
    input wire sub_tick_i, // Subsystem clock half-period pulse
    input wire tmr_match_i, // Timer period-match pulse
    input wire sck_i, // Serial clock pin in
    output reg sck_o, // Serial clock pin out
    output reg sck_oe_o, // Serial clock drive enable
    input wire sdi_i, // Serial input pin
    output reg sdo_o, // Serial output pin
    output reg sdo_oe_o, // Serial output drive enable
    input wire scs_n_i, // Slave select pin, active low
    output reg scs_pin_en_o, // Select pin in use
    output reg spi_active_o // Pins carry the SPI function
);
    localparam ST_IDLE = 3'b001;
    localparam ST_SHIFT = 3'b010;
    // Master waits here while its last capture crosses the synchroniser
    localparam ST_DRAIN = 3'b100;

    reg [7:0] c0_reg;
    reg [7:0] c2_reg;
    reg [7:0] data_reg;
    reg [7:0] shreg_reg;
    reg [2:0] state_reg;
    reg [7:0] rx_reg;
    reg [1:0] cap_dly_reg;
    reg [3:0] edge_reg;
    reg sck_prev_reg;
    reg [7:0] c0_next;
    reg [7:0] c2_next;
    reg [7:0] data_next;
    reg [7:0] shreg_next;
    reg [2:0] state_next;
    reg [7:0] rx_next;
    reg [1:0] cap_dly_next;
    reg [3:0] edge_next;
    reg sdo_next;
    reg sck_next;

    wire [2:0] pins_s;
    wire tick;
    wire sck_s = pins_s[2];
    wire sdi_s = pins_s[1];
    wire scs_n_s = pins_s[0];

    function f_is_spi;
        input [7:0] c0;
        begin
            f_is_spi = !c0[`USP_C0_PROTO] && (c0[`USP_C0_MODE_HI:`USP_C0_MODE_LO] <= `USP_MODE_SLAVE);
        end
    endfunction

    function f_is_master;
        input [7:0] c0;
        begin
            f_is_master = f_is_spi(c0) && (c0[`USP_C0_MODE_HI:`USP_C0_MODE_LO] <= `USP_MODE_TMR);
        end
    endfunction

    function f_txbit;
        input [7:0] d;
        input mls;
        begin
            f_txbit = mls ? d[7] : d[0];
        end
    endfunction

    wire spi_mode = f_is_spi(c0_reg);
    wire enabled = spi_mode && c0_reg[`USP_C0_EN];
    wire master = enabled && f_is_master(c0_reg);
    wire slave = enabled && !f_is_master(c0_reg);
    wire csen = c2_reg[`USP_C2_CSEN];
    wire ckeg = c2_reg[`USP_C2_CKEG];
    wire mls = c2_reg[`USP_C2_MLS];
    wire idle_lvl = !c2_reg[`USP_C2_CKPOLB];
    wire busy = (state_reg != ST_IDLE);
    wire shifting = (state_reg == ST_SHIFT);
    // Select pin ignored when its control bit is off
    wire selected = slave && (!csen || !scs_n_s);
    wire deselect = slave && csen && scs_n_s;
    wire m_edge = master && shifting && tick;
    // The external master makes every clock edge in slave mode
    wire s_edge = selected && (sck_s != sck_prev_reg);
    wire edge_evt = m_edge || s_edge;
    wire leading = !edge_reg[0];
    // Leading edge is capture when the edge bit is set, trailing otherwise
    wire sample = edge_evt && (leading == ckeg);
    wire drive = edge_evt && !sample;
    wire last = edge_evt && (edge_reg == `USP_LAST_EDGE);
    wire wr_c0 = wr_i && (addr_i == `USP_OFS_MODE_CTRL);
    wire wr_c2 = wr_i && (addr_i == `USP_OFS_FORMAT) && spi_mode;
    wire wr_dat = wr_i && (addr_i == `USP_OFS_DATA) && spi_mode;
    wire [7:0] shifted = mls ? {shreg_reg[6:0], sdi_s} : {sdi_s, shreg_reg[7:1]};
    // Master captures two cycles late: sdi needs that long through the synchroniser
    wire m_cap = cap_dly_reg[1];
    // Slave clock and data share the same lag, so it captures at once
    wire s_cap = s_edge && sample;
    wire rx_take = m_cap || s_cap;
    wire [7:0] rx_shift = mls ? {rx_reg[6:0], sdi_s} : {sdi_s, rx_reg[7:1]};

    usp_sync2 #(
        .W(3)
    ) u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i({sck_i, sdi_i, scs_n_i}),
        .sync_o(pins_s)
    );

    usp_rate_gen u_rate (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .run_i(master && busy),
        .mode_i(c0_reg[`USP_C0_MODE_HI:`USP_C0_MODE_LO]),
        .sub_tick_i(sub_tick_i),
        .tmr_match_i(tmr_match_i),
        .tick_o(tick)
    );

    always @* begin
        c0_next = c0_reg;
        c2_next = c2_reg;
        data_next = data_reg;
        shreg_next = shreg_reg;
        state_next = state_reg;
        edge_next = edge_reg;
        sdo_next = sdo_o;
        sck_next = sck_o;
        rx_next = rx_reg;
        cap_dly_next = {cap_dly_reg[0], m_edge && sample};
        // Enable edge resets nothing: software must set controls up first
        if (wr_c0) begin
            c0_next = wdata_i;
        end
        if (wr_c2) begin
            c2_next = wdata_i;
        end
        if (wr_dat && busy) begin
            c2_next[`USP_C2_WCOL] = 1'b1;
        end
        if (rx_take) begin
            rx_next = rx_shift;
        end
        case (state_reg)
            ST_IDLE: begin
                edge_next = 4'h0;
                sck_next = idle_lvl;
                if (!enabled) begin
                    sdo_next = 1'b1;
                end else if (wr_dat) begin
                    data_next = wdata_i;
                    shreg_next = wdata_i;
                    // With trailing-edge capture the line holds until the first edge
                    sdo_next = ckeg ? f_txbit(wdata_i, mls) : 1'b1;
                    if (master) begin
                        state_next = ST_SHIFT;
                        c2_next[`USP_C2_TRF] = 1'b0;
                    end
                end else if (s_edge) begin
                    state_next = ST_SHIFT;
                    c2_next[`USP_C2_TRF] = 1'b0;
                    edge_next = 4'h1;
                    if (sample) begin
                        shreg_next = shifted;
                    end else begin
                        sdo_next = f_txbit(shreg_reg, mls);
                    end
                end else if (slave && ckeg) begin
                    sdo_next = f_txbit(shreg_reg, mls);
                end else begin
                    sdo_next = 1'b1;
                end
            end
            ST_SHIFT: begin
                if (!enabled) begin
                    state_next = ST_IDLE;
                    sdo_next = 1'b1;
                end else if (deselect) begin
                    state_next = ST_IDLE;
                    c0_next[`USP_C0_ICF] = 1'b1;
                    c2_next[`USP_C2_TRF] = 1'b1;
                    sdo_next = 1'b1;
                end else if (edge_evt) begin
                    edge_next = edge_reg + 4'h1;
                    if (master) begin
                        sck_next = !sck_o;
                    end
                    if (sample) begin
                        shreg_next = shifted;
                    end
                    if (drive && !last) begin
                        sdo_next = f_txbit(shreg_reg, mls);
                    end
                    if (last && master) begin
                        state_next = ST_DRAIN;
                    end else if (last) begin
                        state_next = ST_IDLE;
                        data_next = s_cap ? rx_shift : rx_reg;
                        c2_next[`USP_C2_TRF] = 1'b1;
                    end
                    // Hold the last bit through a capture edge; the far end samples it there
                    if (last && !sample) begin
                        sdo_next = 1'b1;
                    end
                end
            end
            ST_DRAIN: begin
                sdo_next = 1'b1;
                if (!enabled) begin
                    state_next = ST_IDLE;
                end else if (!cap_dly_reg[0]) begin
                    state_next = ST_IDLE;
                    data_next = m_cap ? rx_shift : rx_reg;
                    c2_next[`USP_C2_TRF] = 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            c0_reg <= `USP_RST_MODE_CTRL;
            c2_reg <= `USP_RST_FORMAT;
            data_reg <= `USP_RST_DATA;
            shreg_reg <= `USP_RST_DATA;
            rx_reg <= `USP_RST_DATA;
            cap_dly_reg <= 2'h0;
            state_reg <= ST_IDLE;
            edge_reg <= 4'h0;
            sck_prev_reg <= 1'b1;
            sck_o <= 1'b1;
            sdo_o <= 1'b1;
            sck_oe_o <= 1'b0;
            sdo_oe_o <= 1'b0;
            scs_pin_en_o <= 1'b0;
            spi_active_o <= 1'b0;
            rdata_o <= 8'h00;
        end else begin
            c0_reg <= c0_next;
            c2_reg <= c2_next;
            data_reg <= data_next;
            shreg_reg <= shreg_next;
            rx_reg <= rx_next;
            cap_dly_reg <= cap_dly_next;
            state_reg <= state_next;
            edge_reg <= edge_next;
            sck_prev_reg <= sck_s;
            sck_o <= sck_next;
            sdo_o <= sdo_next;
            sck_oe_o <= master;
            sdo_oe_o <= enabled;
            scs_pin_en_o <= enabled && csen;
            spi_active_o <= enabled;
            if (rd_i) begin
                case (addr_i)
                    `USP_OFS_MODE_CTRL: rdata_o <= c0_reg;
                    `USP_OFS_FORMAT: rdata_o <= spi_mode ? c2_reg : 8'h00;
                    `USP_OFS_DATA: rdata_o <= spi_mode ? data_reg : 8'h00;
                    default: rdata_o <= 8'h00;
                endcase
            end else begin
                rdata_o <= 8'h00;
            end
        end
    end
endmodule // usp_spi_port

// file: usp_spi_port_sva.sv
// Checker for the SPI port configuration outputs and serial clock
`timescale 1ns/1ps
module usp_spi_port_sva (
    input wire clk_i, // Clock
    input wire reset_n_i, // Reset, active low
    input wire [1:0] addr_i, // Address
    input wire [7:0] wdata_i, // Write data
    input wire wr_i, // Write strobe
    input wire sck_o, // Clock out
    input wire sck_oe_o, // Clock drive
    input wire sdo_o, // Data out
    input wire sdo_oe_o, // Data drive
    input wire scs_pin_en_o, // Select used
    input wire spi_active_o // SPI on
);
    reg [7:0] c0_q;
    reg [5:2] f_q;
    wire spi_m = !c0_q[4] && c0_q[7:5] <= 3'h5;
    wire act = c0_q[1] && spi_m;
    // Shadow of software settings, seen only through the write port
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            c0_q <= 8'he0;
            f_q <= 4'h0;
        end else begin
            if (wr_i && addr_i == 2'h0) c0_q <= wdata_i;
            if (wr_i && addr_i == 2'h1 && spi_m) f_q <= wdata_i[5:2];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_held;
        $past(c0_q) == c0_q && $past(f_q) == f_q;
    endsequence
    sequence s_tog;
        sck_oe_o && $changed(sck_o);
    endsequence
    cfg_act_a: assert property (s_held |-> spi_active_o == act && sdo_oe_o == act)
        else $error("SPI active or data drive wrong for config");
    sck_drive_a: assert property (s_held |-> sck_oe_o == (act && c0_q[7:5] <= 3'h4))
        else $error("Clock drive wrong for master or slave");
    sel_pin_a: assert property (s_held and spi_m |-> scs_pin_en_o == (c0_q[1] && f_q[2]))
        else $error("Select pin use wrong");
    en_off_a: assert property (!c0_q[1] [*2] |-> !sck_oe_o && !sdo_oe_o && !scs_pin_en_o)
        else $error("Pins driven while disabled");
    sck_base_a: assert property ($rose(sck_oe_o) |=> sck_o == !f_q[5])
        else $error("Clock idle level wrong");
    sdo_base_a: assert property ($rose(sdo_oe_o) |=> sdo_o)
        else $error("Data out not idle high");
    div4_rate_a: assert property (c0_q[7:5] == 3'h0 and s_tog |=> $stable(sck_o))
        else $error("Fast rate half period wrong");
    div16_rate_a: assert property (c0_q[7:5] == 3'h1 and s_tog |=> $stable(sck_o) [*7])
        else $error("Medium rate half period wrong");
endmodule // usp_spi_port_sva
bind usp_spi_port usp_spi_port_sva chk (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .sck_o, .sck_oe_o, .sdo_o,
    .sdo_oe_o, .scs_pin_en_o, .spi_active_o);

// file: usp_spi_peer.sv
// Behavioural SPI slave device facing the port in master mode
`timescale 1ns/1ps
module usp_spi_peer (
    input wire clk_i, // System clock
    input wire arm_i, // Load byte to send
    input wire [7:0] tx_i, // Byte to send
    input wire [2:0] cfg_i, // Polarity, edge, order
    input wire sck_i, // Clock from master
    input wire sdo_i, // Master data out
    output logic sdi_o = 1'b0, // Data to master
    output logic [7:0] rx_o = 8'h00 // Byte received
);
    int idx = 8;
    function automatic logic pick(input int k);
        pick = cfg_i[0] ? tx_i[7 - k] : tx_i[k];
    endfunction
    // Arm after setup: the idle level change on the format write is not a data edge
    always @(posedge clk_i) begin
        if (arm_i) begin
            idx <= cfg_i[1] ? 1 : 0;
            sdi_o <= cfg_i[1] ? pick(0) : ~sdi_o;
        end
    end
    always @(sck_i) begin
        if (sck_i == (cfg_i[2] == cfg_i[1])) begin
            rx_o <= cfg_i[0] ? {rx_o[6:0], sdo_i} : {sdo_i, rx_o[7:1]};
        end else if (idx < 8) begin
            sdi_o <= pick(idx);
            idx <= idx + 1;
        end else begin
            sdi_o <= ~sdi_o;
        end
    end
endmodule // usp_spi_peer

// file: usp_spi_port_test.sv
// Self-checking bench for the SPI port
`timescale 1ns/1ps
module usp_spi_port_test;
    logic clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, sub_tick_i = 0, tmr_match_i = 0;
    logic sck_tb = 1, sdi_tb = 0, scs_n_i = 1, slv = 0, arm = 0, rd_d = 0;
    logic [1:0] addr_i = 0;
    logic [7:0] wdata_i = 0, ptx = 0, f, tx, rxv, sb, sr;
    logic [2:0] pcfg = 0, md;
    logic [2:0] mtab [11] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 3, 4};
    logic [15:0] expq [$];
    int err_total = 0, n_checks = 0, tk = 0;
    wire [7:0] rdata_o, prx;
    wire sck_o, sck_oe_o, sdo_o, sdo_oe_o, scs_pin_en_o, spi_active_o, sdi_p;
    wire sck_i = sck_oe_o ? sck_o : sck_tb;
    wire sdi_i = slv ? sdi_tb : sdi_p;
    usp_spi_port dut (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sub_tick_i, .tmr_match_i,
        .sck_i, .sck_o, .sck_oe_o, .sdi_i, .sdo_o, .sdo_oe_o, .scs_n_i, .scs_pin_en_o, .spi_active_o);
    usp_spi_peer peer (.clk_i, .arm_i(arm), .tx_i(ptx), .cfg_i(pcfg), .sck_i(sck_o), .sdo_i(sdo_o),
        .sdi_o(sdi_p), .rx_o(prx));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        tk <= tk + 1;
        sub_tick_i <= tk % 6 == 0;
        tmr_match_i <= tk % 4 == 0;
    end
    // Read monitor: oldest note against the data standing after the strobe
    always @(posedge clk_i) begin
        rd_d <= rd_i;
        if (rd_d && expq[0][15:8] != 8'h00) chk("rdata_o", expq[0][7:0], rdata_o, expq[0][15:8]);
        if (rd_d) void'(expq.pop_front());
    end
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
        n_checks++;
        if ((g & m) !== (e & m)) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e & m, g & m);
        end
    endtask
    // Mask zero marks a poll read with no expectation
    task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge clk_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        if (!w) expq.push_back({m, d});
        @(posedge clk_i);
        wr_i <= 0;
        rd_i <= 0;
    endtask
    task automatic wait_trf();
        for (int k = 0; k < 400; k++) begin
            bus(0, 2'h1, 8'h00, 8'h00);
            #1;
            if (rdata_o[0] === 1'b1) break;
        end
        repeat (8) @(posedge clk_i);
    endtask
    task automatic setup(input logic [2:0] m, input logic [7:0] fm);
        bus(1, 2'h0, {m, 5'h00}, 0);
        bus(1, 2'h1, fm, 0);
        bus(1, 2'h0, {m, 5'h02}, 0);
    endtask
    // Bench as external master: idle high, launch on fall, capture on rise
    task automatic sxfer(input logic [7:0] b, input int n, input logic sel, input logic [7:0] so);
        logic [7:0] got;
        got = 8'h00;
        @(posedge clk_i);
        slv <= 1;
        scs_n_i <= !sel;
        repeat (6) @(posedge clk_i);
        for (int k = 0; k < n; k++) begin
            sck_tb <= k[0];
            if (!k[0]) sdi_tb <= b[7 - k / 2];
            if (k[0]) got = {got[6:0], sdo_o};
            repeat (6) @(posedge clk_i);
        end
        scs_n_i <= 1;
        sdi_tb <= ~sdi_tb;
        if (n == 16) chk("sdo_o", so, got, 8'hff);
        repeat (6) @(posedge clk_i);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        void'($urandom(32'haf67));
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1;
        repeat (2) @(posedge clk_i);
        bus(1, 2'h3, 8'h5a, 0);
        bus(0, 2'h0, 8'he0, 8'hff);
        bus(0, 2'h3, 8'h00, 8'hff);
        bus(1, 2'h1, 8'hc0, 0);
        bus(0, 2'h1, 8'h00, 8'hff);
        bus(1, 2'h0, 8'h1c, 0);
        bus(1, 2'h1, 8'hc0, 0);
        bus(0, 2'h1, 8'h00, 8'hff);
        bus(0, 2'h0, 8'h1c, 8'hff);
        bus(1, 2'h0, 8'hce, 0);
        bus(0, 2'h1, 8'h00, 8'hff);
        bus(1, 2'h0, 8'hee, 0);
        bus(1, 2'h0, 8'h0c, 0);
        bus(1, 2'h1, 8'hc0, 0);
        bus(0, 2'h1, 8'hc0, 8'hff);
        $display("test registers done");
        for (int i = 0; i < 11; i++) begin
            md = mtab[i];
            f = {2'b00, i[2:0], 3'b000};
            tx = $urandom;
            rxv = $urandom;
            setup(md, f);
            @(posedge clk_i);
            pcfg <= i[2:0];
            ptx <= rxv;
            arm <= 1;
            @(posedge clk_i);
            arm <= 0;
            bus(1, 2'h2, tx, 0);
            bus(1, 2'h2, ~tx, 0);
            bus(0, 2'h1, 8'h02, 8'h03);
            wait_trf();
            bus(0, 2'h1, f | 8'h03, 8'hff);
            bus(0, 2'h2, rxv, 8'hff);
            chk("peer rx", tx, prx, 8'hff);
            bus(1, 2'h1, f, 0);
            bus(0, 2'h1, f, 8'hff);
        end
        $display("test master done");
        sb = $urandom;
        sr = $urandom;
        setup(3'h5, 8'h0c);
        bus(0, 2'h1, 8'h0c, 8'hff);
        bus(1, 2'h2, sr, 0);
        sxfer(sb, 16, 1, sr);
        bus(0, 2'h2, sb, 8'hff);
        bus(0, 2'h0, 8'ha2, 8'hff);
        bus(0, 2'h1, 8'h0d, 8'hff);
        bus(1, 2'h1, 8'h0c, 0);
        sxfer(sb, 6, 1, sr);
        bus(0, 2'h0, 8'ha3, 8'hff);
        bus(0, 2'h1, 8'h0d, 8'hff);
        bus(1, 2'h1, 8'h0c, 0);
        bus(1, 2'h0, 8'ha2, 0);
        bus(1, 2'h0, 8'ha3, 0);
        bus(0, 2'h1, 8'h0c, 8'hff);
        setup(3'h5, 8'h08);
        bus(1, 2'h2, sr, 0);
        sxfer(~sb, 16, 0, sr);
        bus(0, 2'h2, ~sb, 8'hff);
        $display("test slave done");
        complete_run();
    end
    initial begin
        #400000;
        err_total++;
        complete_run();
    end
endmodule // usp_spi_port_test
